// *** inc/tcd_pkg.sv ***
// timer clock divider chains: shared constants, types and helpers
// assumes one oscillator clock domain and a plain register port

package tcd_pkg;

   // ----------------------------------------------------------------
   // register port
   // ----------------------------------------------------------------
   localparam int         ADDR_W            = 4;
   localparam int         DATA_W            = 16;
   localparam logic [3:0] OFF_COUNT         = 4'h0;
   localparam logic [3:0] OFF_FLAG_TWO      = 4'h1;
   localparam logic [3:0] OFF_MASK_TWO      = 4'h2;
   localparam logic [3:0] OFF_SERIAL_CTRL   = 4'h3;
   localparam logic [3:0] OFF_OPTIONS_TWO   = 4'h4;
   localparam logic [3:0] OFF_PULSE_COUNT   = 4'h5;

   // ----------------------------------------------------------------
   // field positions and reset values
   // ----------------------------------------------------------------
   localparam int          FLAG_OVF_BIT      = 7;
   localparam int          MASK_OVF_IE_BIT   = 7;
   localparam int          MASK_PRESCALE_LSB = 0;
   localparam int          SERIAL_RATE_LSB   = 0;
   localparam int          SYSTEM_OPTIONS_TWO_RATE_HI_BIT  = 2;
   localparam logic [15:0] COUNT_RESET       = 16'h0000;
   localparam logic [15:0] COUNT_MAX         = 16'hFFFF;
   localparam logic [1:0]  PRESCALE_RESET    = 2'h0;

   // ----------------------------------------------------------------
   // divider ratios and timing counts
   // ----------------------------------------------------------------
   localparam logic [1:0]  OSC_PER_BUS_M1    = 2'h3;
   localparam logic [6:0]  PRESCALE_WINDOW   = 7'h40;
   localparam int          PULSE_DIV         = 64;
   localparam int          PERIODIC_DIV      = 8192;
   localparam logic [1:0]  WATCHDOG_POST_M1  = 2'h3;

   // ----------------------------------------------------------------
   // carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic              wr;
      logic              rd;
   } tcd_bus_req_s;

   typedef struct packed {
      logic busTick;
      logic timerTick;
      logic serialTick;
      logic pulseTick;
      logic periodicTick;
      logic watchdogTick;
   } tcd_ticks_s;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   // log2 of the main timer divisor: 1, 4, 8, 16
   function automatic int prescaleShift(input logic [1:0] sel);
      case (sel)
         2'h0:    prescaleShift = 0;
         2'h1:    prescaleShift = 2;
         2'h2:    prescaleShift = 3;
         default: prescaleShift = 4;
      endcase
   endfunction

   // serial divisor in bus clocks for {high, low[1:0]}
   function automatic int serialDiv(input logic [2:0] sel);
      case (sel)
         3'h0:    serialDiv = 2;
         3'h1:    serialDiv = 4;
         3'h2:    serialDiv = 16;
         3'h3:    serialDiv = 32;
         3'h4:    serialDiv = 8;
         3'h5:    serialDiv = 16;
         3'h6:    serialDiv = 64;
         default: serialDiv = 128;
      endcase
   endfunction

endpackage

// *** design/tcd_tick_div.sv ***
// enable-pulse divider: one tick per (limit+1) input enables
// assumes limit is held steady apart from rare software changes

`timescale 1ns/1ps

module tcd_tick_div #(
   parameter int W = 4
) (
   input  wire logic         core_clk,   // oscillator clock
   input  wire logic         reset_n,    // async reset, active low
   input  wire logic         en,         // input rate enable
   input  wire logic [W-1:0] limit,      // divisor minus one
   output logic              tick        // one-cycle output enable
);

   logic [W-1:0] cnt_ff;
   logic [W-1:0] nxt_cnt;
   logic         atEnd;

   // >= so a lowered limit never lets the count run past and stall
   assign atEnd   = (cnt_ff >= limit);
   assign tick    = en && atEnd;
   assign nxt_cnt = atEnd ? '0 : W'(cnt_ff + 1'b1);

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         cnt_ff <= '0;
      end else if (en) begin
         cnt_ff <= nxt_cnt;
      end
   end

endmodule // tcd_tick_div

// *** design/tcd_timer_chains.sv ***
// timer clock divider chains with free-running counter and overflow flag
// assumes core_clk is the oscillator; software is the only other party

`timescale 1ns/1ps

module tcd_timer_chains
   import tcd_pkg::*;
(
   input  wire logic              core_clk,     // oscillator clock, 10 MHz
   input  wire logic              reset_n,      // async reset, active low
   input  wire logic              specialMode,  // high in special modes
   input  wire tcd_bus_req_s      busReq,       // register request
   output logic [DATA_W-1:0]      rdData,       // read data, cycle after read
   output tcd_ticks_s             chainTicks,   // divider chain enables
   output logic                   ovfIrq        // overflow interrupt request
);

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   logic [15:0]       count_ff;
   logic [15:0]       nxt_count;
   logic              ovfFlag_ff;
   logic              nxt_ovfFlag;
   logic              ovfIe_ff;
   logic [1:0]        prescale_ff;
   logic              prescaleLocked_ff;
   logic [6:0]        window_ff;
   logic [1:0]        serialLow_ff;
   logic              serialHigh_ff;
   logic [7:0]        pulseCount_ff;
   logic [DATA_W-1:0] rdData_ff;

   // ----------------------------------------------------------------
   // address decode
   // ----------------------------------------------------------------
   wire hitCount  = (busReq.addr == OFF_COUNT);
   wire hitFlag   = (busReq.addr == OFF_FLAG_TWO);
   wire hitMask   = (busReq.addr == OFF_MASK_TWO);
   wire hitSerial = (busReq.addr == OFF_SERIAL_CTRL);
   wire hitOpt    = (busReq.addr == OFF_OPTIONS_TWO);
   wire hitPulse  = (busReq.addr == OFF_PULSE_COUNT);

   wire wrCount   = busReq.wr && hitCount && specialMode;
   wire wrFlag    = busReq.wr && hitFlag;
   wire wrMask    = busReq.wr && hitMask;
   wire windowOpen = (window_ff < PRESCALE_WINDOW);
   // special modes leave the prescale open for test
   wire wrPrescale = wrMask && (specialMode || (!prescaleLocked_ff && windowOpen));

   // ----------------------------------------------------------------
   // divider chains
   // ----------------------------------------------------------------
   logic busTick;
   logic timerTick;
   logic serialTick;
   logic pulseTick;
   logic periodicTick;
   logic watchdogTick;

   wire [3:0]  prescaleLimit = 4'((1 << prescaleShift(prescale_ff)) - 1);
   wire [6:0]  serialLimit   = 7'(serialDiv({serialHigh_ff, serialLow_ff}) - 1);
   wire [5:0]  pulseLimit    = 6'((PULSE_DIV >> prescaleShift(prescale_ff)) - 1);
   wire [12:0] periodicLimit = 13'((PERIODIC_DIV >> prescaleShift(prescale_ff)) - 1);

   // oscillator over four gives the bus clock enable
   tcd_tick_div #(.W(2)) uBusDiv (
      .core_clk (core_clk),
      .reset_n  (reset_n),
      .en       (1'b1),
      .limit    (OSC_PER_BUS_M1),
      .tick     (busTick)
   );

   tcd_tick_div #(.W(4)) uPrescale (
      .core_clk (core_clk),
      .reset_n  (reset_n),
      .en       (busTick),
      .limit    (prescaleLimit),
      .tick     (timerTick)
   );

   // serial chain runs on the bus clock, not on the main timer
   tcd_tick_div #(.W(7)) uSerial (
      .core_clk (core_clk),
      .reset_n  (reset_n),
      .en       (busTick),
      .limit    (serialLimit),
      .tick     (serialTick)
   );

   // post-scalers shrink as the prescale grows, so rates stay fixed
   tcd_tick_div #(.W(6)) uPulse (
      .core_clk (core_clk),
      .reset_n  (reset_n),
      .en       (timerTick),
      .limit    (pulseLimit),
      .tick     (pulseTick)
   );

   tcd_tick_div #(.W(13)) uPeriodic (
      .core_clk (core_clk),
      .reset_n  (reset_n),
      .en       (timerTick),
      .limit    (periodicLimit),
      .tick     (periodicTick)
   );

   tcd_tick_div #(.W(2)) uWatchdog (
      .core_clk (core_clk),
      .reset_n  (reset_n),
      .en       (periodicTick),
      .limit    (WATCHDOG_POST_M1),
      .tick     (watchdogTick)
   );

   // ----------------------------------------------------------------
   // free-running counter and overflow flag
   // ----------------------------------------------------------------
   wire wrapNow = timerTick && (count_ff == COUNT_MAX);

   // a special-mode write wins over the count in the same cycle
   assign nxt_count = wrCount   ? busReq.wdata :
                      timerTick ? 16'(count_ff + 16'h0001) :
                                  count_ff;

   // set wins over a same-cycle write-one clear
   assign nxt_ovfFlag = wrapNow ? 1'b1 :
                        (wrFlag && busReq.wdata[FLAG_OVF_BIT]) ? 1'b0 :
                        ovfFlag_ff;

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         count_ff   <= COUNT_RESET;
         ovfFlag_ff <= 1'b0;
      end else begin
         count_ff   <= nxt_count;
         ovfFlag_ff <= nxt_ovfFlag;
      end
   end

   // ----------------------------------------------------------------
   // control registers
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         ovfIe_ff          <= 1'b0;
         prescale_ff       <= PRESCALE_RESET;
         prescaleLocked_ff <= 1'b0;
         window_ff         <= '0;
         serialLow_ff      <= 2'h0;
         serialHigh_ff     <= 1'b0;
      end else begin
         if (wrMask) begin
            ovfIe_ff <= busReq.wdata[MASK_OVF_IE_BIT];
         end
         if (wrPrescale) begin
            prescale_ff       <= busReq.wdata[MASK_PRESCALE_LSB +: 2];
            prescaleLocked_ff <= 1'b1;
         end
         if (busTick && windowOpen) begin
            window_ff <= 7'(window_ff + 7'h01);
         end
         if (busReq.wr && hitSerial) begin
            serialLow_ff <= busReq.wdata[SERIAL_RATE_LSB +: 2];
         end
         if (busReq.wr && hitOpt) begin
            serialHigh_ff <= busReq.wdata[SYSTEM_OPTIONS_TWO_RATE_HI_BIT];
         end
      end
   end

   // 8-bit accumulator stepped by the pulse chain
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         pulseCount_ff <= 8'h00;
      end else if (pulseTick) begin
         pulseCount_ff <= 8'(pulseCount_ff + 8'h01);
      end
   end

   // ----------------------------------------------------------------
   // read path
   // ----------------------------------------------------------------
   logic [DATA_W-1:0] rdMux;

   always_comb begin
      rdMux = '0;
      if (hitCount) begin
         rdMux = count_ff;
      end else if (hitFlag) begin
         rdMux[FLAG_OVF_BIT] = ovfFlag_ff;
      end else if (hitMask) begin
         rdMux[MASK_OVF_IE_BIT] = ovfIe_ff;
         rdMux[MASK_PRESCALE_LSB +: 2] = prescale_ff;
      end else if (hitSerial) begin
         rdMux[SERIAL_RATE_LSB +: 2] = serialLow_ff;
      end else if (hitOpt) begin
         rdMux[SYSTEM_OPTIONS_TWO_RATE_HI_BIT] = serialHigh_ff;
      end else if (hitPulse) begin
         rdMux[7:0] = pulseCount_ff;
      end
   end

   // read data stand only in the cycle after the read
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         rdData_ff <= '0;
      end else if (busReq.rd) begin
         rdData_ff <= rdMux;
      end else begin
         rdData_ff <= '0;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign rdData = rdData_ff;
   assign ovfIrq = ovfFlag_ff && ovfIe_ff;

   assign chainTicks.busTick      = busTick;
   assign chainTicks.timerTick    = timerTick;
   assign chainTicks.serialTick   = serialTick;
   assign chainTicks.pulseTick    = pulseTick;
   assign chainTicks.periodicTick = periodicTick;
   assign chainTicks.watchdogTick = watchdogTick;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   chk_bus_tick_period: assert property (
      @(posedge core_clk) disable iff (!reset_n)
      busTick |=> !busTick [*3] ##1 busTick)
      else $error("bus tick not every fourth oscillator cycle");

   chk_prescale_unity: assert property (
      @(posedge core_clk) disable iff (!reset_n)
      (prescale_ff == 2'h0) |-> (timerTick == busTick))
      else $error("divide by one does not follow the bus tick");

   chk_prescale_sixteen: assert property (
      @(posedge core_clk) disable iff (!reset_n)
      (timerTick && prescale_ff == 2'h3 && $stable(prescale_ff))
         |=> !timerTick [*8] ##0 (prescale_ff == 2'h3))
      else $error("divide by sixteen ticks too early");

   chk_count_step: assert property (
      @(posedge core_clk) disable iff (!reset_n)
      (timerTick && !wrCount) |=> (count_ff == 16'($past(count_ff) + 16'h0001)))
      else $error("counter did not advance on timer tick");

   chk_count_hold: assert property (
      @(posedge core_clk) disable iff (!reset_n)
      (!timerTick && !wrCount) |=> $stable(count_ff))
      else $error("counter changed without tick or special write");

   chk_normal_write: assert property (
      @(posedge core_clk) disable iff (!reset_n)
      (busReq.wr && hitCount && !specialMode && !timerTick) |=> $stable(count_ff))
      else $error("normal mode write altered the counter");

   chk_wrap_flag: assert property (
      @(posedge core_clk) disable iff (!reset_n)
      wrapNow && !wrCount |=> (count_ff == COUNT_RESET) && ovfFlag_ff)
      else $error("wrap did not clear count and set flag");

   chk_flag_clear: assert property (
      @(posedge core_clk) disable iff (!reset_n)
      (wrFlag && busReq.wdata[FLAG_OVF_BIT] && !wrapNow) |=> !ovfFlag_ff)
      else $error("write one did not clear overflow flag");

   chk_flag_keep: assert property (
      @(posedge core_clk) disable iff (!reset_n)
      (ovfFlag_ff && !(wrFlag && busReq.wdata[FLAG_OVF_BIT])) |=> ovfFlag_ff)
      else $error("overflow flag lost without a write one");

   chk_irq_gate: assert property (
      @(posedge core_clk) disable iff (!reset_n)
      (wrapNow && ovfIe_ff && !wrMask) |=> ovfIrq)
      else $error("overflow with enable set raised no interrupt request");

   chk_prescale_lock: assert property (
      @(posedge core_clk) disable iff (!reset_n)
      (wrMask && !specialMode && (prescaleLocked_ff || !windowOpen))
         |=> $stable(prescale_ff))
      else $error("locked prescale select was changed");

   chk_pulse_on_timer: assert property (
      @(posedge core_clk) disable iff (!reset_n)
      pulseTick |-> timerTick)
      else $error("pulse chain ticked off the main timer");

   chk_watchdog_sync: assert property (
      @(posedge core_clk) disable iff (!reset_n)
      watchdogTick |-> (periodicTick && timerTick))
      else $error("watchdog tick without periodic tick");

   chk_read_latency: assert property (
      @(posedge core_clk) disable iff (!reset_n)
      (busReq.rd && hitCount) |=> (rdData == $past(count_ff)))
      else $error("count read data wrong in cycle after read");

endmodule // tcd_timer_chains

// *** sim/tcd_timer_chains_tb.sv ***
// self-checking bench for the timer clock divider chains
// assumes the package in inc/ and the design top in design/, one 10 MHz clock

`timescale 1ns/1ps

module tcd_timer_chains_tb
   import tcd_pkg::*;
();

   // ----------------------------------------------------------------
   // signals
   // ----------------------------------------------------------------
   logic              core_clk = 1'b0;
   logic              reset_n;
   logic              specialMode;
   tcd_bus_req_s      busReq;
   logic [DATA_W-1:0] rdData;
   tcd_ticks_s        chainTicks;
   logic              ovfIrq;
   int                failures = 0;
   int                comparisons = 0;
   logic [31:0]       rngState = 32'd14073;
   logic              sawWatchdog = 1'b0;

   localparam int SER_DIV [8] = '{2, 4, 16, 32, 8, 16, 64, 128};

   always #50 core_clk = ~core_clk;

   // sticky: any watchdog tick since the run began
   always @(negedge core_clk) begin
      if (chainTicks.watchdogTick === 1'b1) begin
         sawWatchdog <= 1'b1;
      end
   end

   tcd_timer_chains i_tcd_timer_chains (
      .core_clk    (core_clk),
      .reset_n     (reset_n),
      .specialMode (specialMode),
      .busReq      (busReq),
      .rdData      (rdData),
      .chainTicks  (chainTicks),
      .ovfIrq      (ovfIrq)
   );

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [15:0] nextRand();
      rngState = rngState ^ (rngState << 13);
      rngState = rngState ^ (rngState >> 17);
      rngState = rngState ^ (rngState << 5);
      return rngState[15:0];
   endfunction

   // core clocks per counter step: four per bus cycle times the divisor
   function automatic int prescaleExpect(input logic [1:0] sel);
      case (sel)
         2'h0:    return 4 * 1;
         2'h1:    return 4 * 4;
         2'h2:    return 4 * 8;
         default: return 4 * 16;
      endcase
   endfunction

   function automatic int serialExpect(input logic [2:0] sel);
      return 4 * SER_DIV[sel];
   endfunction

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         failures++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic regWr(input logic [3:0] a, input logic [15:0] d);
      @(posedge core_clk);
      busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge core_clk);
      busReq.wr <= 1'b0;
   endtask

   task automatic regRd(input logic [3:0] a, output logic [15:0] d);
      @(posedge core_clk);
      busReq <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
      @(posedge core_clk);
      busReq.rd <= 1'b0;
      @(negedge core_clk);
      d = rdData;
   endtask

   // skips some ticks first, since a divisor change leaves one odd gap
   task automatic measure(input int idx, input int skip, output int per);
      int n;
      n = 0;
      repeat (skip + 1) begin
         @(negedge core_clk);
         while (chainTicks[idx] !== 1'b1 && n < 70000) begin
            @(negedge core_clk);
            n++;
         end
      end
      per = 0;
      do begin
         @(negedge core_clk);
         per++;
      end while (chainTicks[idx] !== 1'b1 && per < 70000);
   endtask

   task automatic doReset();
      reset_n <= 1'b0;
      repeat (12) @(posedge core_clk);
      reset_n <= 1'b1;
   endtask

   task automatic print_verdict();
      $display("comparisons=%0d failures=%0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      int          per;
      int          i;
      logic [15:0] d;
      logic [15:0] c1;
      logic [15:0] v;
      specialMode = 1'b0;
      busReq = '0;
      doReset();
      regRd(OFF_COUNT, d);
      chk(d, 16'h0000);
      regWr(OFF_MASK_TWO, 16'h0001);
      measure(5, 1, per);
      chk(per, 4);
      measure(4, 1, per);
      chk(per, prescaleExpect(2'h1));
      regWr(OFF_MASK_TWO, 16'h0003);
      measure(4, 1, per);
      chk(per, prescaleExpect(2'h1));
      measure(2, 1, per);
      chk(per, 4 * 64);
      measure(1, 0, per);
      chk(per, 4 * (1 << 13));
      // fewer than four periodic ticks so far, so no watchdog tick yet
      chk(sawWatchdog, 1'b0);
      regRd(OFF_COUNT, c1);
      regWr(OFF_COUNT, c1 - 16'h0100);
      regRd(OFF_COUNT, d);
      chk(32'(d - c1 <= 16'h0001), 32'h1);
      for (i = 0; i < 4; i++) begin
         regRd(4'(6 + nextRand() % 10), d);
         chk(d, 16'h0000);
      end
      for (i = 0; i < 8; i++) begin
         regWr(OFF_SERIAL_CTRL, 16'(i & 3));
         regWr(OFF_OPTIONS_TWO, 16'((i >> 2) << SYSTEM_OPTIONS_TWO_RATE_HI_BIT));
         measure(3, 1, per);
         chk(per, serialExpect(3'(i)));
      end
      // fresh reset, then a first prescale write that comes too late
      @(posedge core_clk);
      doReset();
      repeat (300) @(posedge core_clk);
      regWr(OFF_MASK_TWO, 16'h0002);
      measure(4, 1, per);
      chk(per, prescaleExpect(2'h0));
      @(posedge core_clk);
      specialMode <= 1'b1;
      for (i = 0; i < 4; i++) begin
         regWr(OFF_MASK_TWO, 16'(i));
         measure(4, 1, per);
         chk(per, prescaleExpect(2'(i)));
         measure(2, 1, per);
         chk(per, 4 * 64);
      end
      // read just after a pulse tick, then three more ticks pass
      regRd(OFF_PULSE_COUNT, c1);
      measure(2, 1, per);
      regRd(OFF_PULSE_COUNT, d);
      chk(d, 16'(c1 + 16'h0003));
      // divide by 16 keeps more than one step from landing between write and read
      for (i = 0; i < 6; i++) begin
         v = nextRand();
         regWr(OFF_COUNT, v);
         regRd(OFF_COUNT, d);
         chk(32'(d - v <= 16'h0001), 32'h1);
      end
      // keep the prescale change clear of the eight cycles after a tick
      measure(4, 0, per);
      repeat (16) @(posedge core_clk);
      regWr(OFF_MASK_TWO, 16'h0080);
      regWr(OFF_FLAG_TWO, 16'h0080);
      regWr(OFF_COUNT, 16'hFFFD);
      regRd(OFF_FLAG_TWO, d);
      chk(d, 16'h0000);
      repeat (16) @(posedge core_clk);
      regRd(OFF_FLAG_TWO, d);
      chk(d, 16'h0080);
      chk(ovfIrq, 1'b1);
      regRd(OFF_COUNT, d);
      chk(32'(d < 16'h0010), 32'h1);
      regWr(OFF_FLAG_TWO, 16'h0000);
      regRd(OFF_FLAG_TWO, d);
      chk(d, 16'h0080);
      regWr(OFF_MASK_TWO, 16'h0000);
      @(negedge core_clk);
      chk(ovfIrq, 1'b0);
      regWr(OFF_FLAG_TWO, 16'h0080);
      regRd(OFF_FLAG_TWO, d);
      chk(d, 16'h0000);
      print_verdict();
   end

   // ----------------------------------------------------------------
   // watchdog
   // ----------------------------------------------------------------
   // whole sequence needs about 75k cycles, two periodic ticks of it
   initial begin
      repeat (90000) @(posedge core_clk);
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
      print_verdict();
   end

endmodule // tcd_timer_chains_tb
